// ### hdl/hsf_rx_status.sv
// hsf_rx_status: receive status, byte counts and clear-on-read event flags
// assumes rx events arrive as one-cycle pulses from logic on clk_i
//
// Operation
// R1: compare received high address byte with two registers and broadcast fe, fc
// R2: high byte result only meaningful in two-byte address or ss7 mode
// R3: high result codes: 00 match b, 01 broadcast, 10/11 match a with c/r
// R4: equal high registers report match a codes, never match b
// R5: in ss7 mode field gives signal unit type 00/01/10/11
// R6: low byte compared with two registers: 0 match b, 1 match a
// R7: twelve-bit frame length split over low and high count registers
// R8: lowest five count bits give valid bytes held in receive fifo
// R9: host reads count registers after each message end event
// R10: reading flags 0 clears all its bits
// R11: reading flags 1 clears all its bits
// R12: masked events still flagged but hidden from irq and summary when shown
// R13: message end set when short message or last part plus status stored
// R14: pool full set when 32 bytes of an incomplete frame stored
// R15: frame start raised two bytes after valid start; address and status valid
// R16: 8 ms multiframe search timeout, never in multiframe sync state
// R17: multiframe begin every 2 ms, or every 512-bit doubleframe if format 00
// R18: cas changed after sixteen registers update with different content, sync only
// R19: host reads signaling registers within 2 ms of cas changed
// R20: crc4 flag reads 1 when last submultiframe check failed
// R21: sa6 change flag set on every change of sa6 combination state; code flags it only while basic frame alignment is held
// R22: loopback change after 25 ms pattern detect, and when error rate exceeded
// R23: status byte describes last frame and is appended as last fifo byte
// R24: irq asserted while any unmasked flag set, drops once flags read
`timescale 1ns/1ps
`default_nettype none
module hsf_rx_status
  import hsf_pkg::*;
#(
  parameter int MF_TIMEOUT_CYCLES = hsf_pkg::MF_TIMEOUT_CYC,
  parameter int LOOP_DETECT_CYCLES = hsf_pkg::LOOP_DETECT_CYC,
  parameter int FIFO_BITS = 5
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset, high
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  input wire logic we_i, // wishbone write
  input wire logic [7:0] adr_i, // byte address
  input wire logic [3:0] sel_i, // byte lanes
  input wire logic [31:0] dat_i, // write data
  output logic [31:0] dat_o, // read data
  output logic ack_o, // wishbone ack
  output logic irq_o, // interrupt, high
  input wire logic rx_byte_i, // byte entered fifo
  input wire logic [7:0] rx_data_i, // that byte
  input wire logic rx_frame_open_i, // opening flag seen
  input wire logic rx_frame_end_i, // closing flag seen
  input wire logic [7:0] rx_status_i, // status of ending frame
  input wire logic [1:0] rx_su_type_i, // ss7 unit type at end
  input wire logic host_pop_i, // host took a fifo byte
  input wire logic fifo_to_fifo_o_unused_i, // reserved, ignored
  output logic [7:0] fifo_data_o, // byte to fifo
  output logic fifo_push_o, // fifo write strobe
  input wire logic basic_align_lost_i, // basic frame alignment lost
  input wire logic mf_sync_i, // multiframe synchronous
  input wire logic mf_start_i, // multiframe/doubleframe boundary
  input wire logic cas_update_done_i, // sixteen sig regs updated
  input wire logic cas_differs_i, // new cas differs from old
  input wire logic ts16_sync_i, // ts0 and ts16 synchronous
  input wire logic crc4_done_i, // submultiframe checked
  input wire logic crc4_fail_i, // that check failed
  input wire logic [2:0] sa6_state_i, // sa6 combination state
  input wire logic loop_act_pat_i, // activate pattern present
  input wire logic loop_deact_pat_i, // deactivate pattern present
  input wire logic ber_low_i, // error rate below 1e-2
  input wire logic prbs_sync_i // prbs synchroniser state
);
  import hsf_pkg::*;

  typedef enum logic [1:0] {HSF_IDLE, HSF_ADDR_HI, HSF_ADDR_LO, HSF_BODY} hsf_rx_t;

  // elaboration check: count field and timers need these ranges
  if (FIFO_BITS != 5 || MF_TIMEOUT_CYCLES < 1 || LOOP_DETECT_CYCLES < 1) begin : g_param_check
    $error("hsf_rx_status: unsupported parameter");
  end

  logic [7:0] flags_0, flags_1, mask_0, mask_1, cfg;
  logic [7:0] high_addr_match_a, high_addr_match_b, low_addr_match_a, low_addr_match_b;
  logic [1:0] addr_result_hi;
  logic low_addr_result;
  logic [11:0] rx_byte_count;
  logic [FIFO_BITS:0] fifo_level; // one spare bit so the pop guard does not take a full pool as empty
  logic [11:0] frame_len;
  logic [5:0] pool_cnt;
  logic [1:0] fs_delay;
  logic fs_armed;
  hsf_rx_t rx_state;
  logic [7:0] hi_byte;
  logic [31:0] mf_timer, loop_timer;
  logic [2:0] sa6_prev;
  logic loop_detected, prbs_prev;
  logic [7:0] ev_0, ev_1;
  logic rd_flags_0, rd_flags_1, bus_req, wr_en;
  logic [7:0] next_dat;
  logic [7:0] global_event_summary;

  assign bus_req = cyc_i && stb_i && !ack_o;
  assign wr_en = bus_req && we_i && sel_i[0];
  assign rd_flags_0 = bus_req && !we_i && adr_i == ADDR_FLAGS_0;
  assign rd_flags_1 = bus_req && !we_i && adr_i == ADDR_FLAGS_1;

  // control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_0 <= RST_MASK;
      mask_1 <= RST_MASK;
      cfg <= RST_CONFIG;
      high_addr_match_a <= RST_ADDR;
      high_addr_match_b <= RST_ADDR;
      low_addr_match_a <= RST_ADDR;
      low_addr_match_b <= RST_ADDR;
    end else if (wr_en) begin
      case (adr_i)
        ADDR_MASK_0: mask_0 <= dat_i[7:0];
        ADDR_MASK_1: mask_1 <= dat_i[7:0];
        ADDR_CONFIG: cfg <= dat_i[7:0];
        ADDR_HIGH_MATCH_A: high_addr_match_a <= dat_i[7:0];
        ADDR_HIGH_MATCH_B: high_addr_match_b <= dat_i[7:0];
        ADDR_LOW_MATCH_A: low_addr_match_a <= dat_i[7:0];
        ADDR_LOW_MATCH_B: low_addr_match_b <= dat_i[7:0];
        default: ;
      endcase
    end
  end

  // frame receive sequencer and address compare
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state <= HSF_IDLE;
      hi_byte <= 8'h00;
      addr_result_hi <= 2'h0;
      low_addr_result <= 1'b0;
      frame_len <= 12'h000;
      rx_byte_count <= 12'h000;
      fs_armed <= 1'b0;
    end else begin
      fs_armed <= 1'b0;
      if (rx_frame_open_i) begin
        frame_len <= 12'h000;
        rx_state <= cfg[CFG_TRANSPARENT] ? HSF_BODY : (cfg[CFG_TWO_BYTE] ? HSF_ADDR_HI : HSF_ADDR_LO);
        fs_armed <= cfg[CFG_TRANSPARENT]; // R15
      end else if (rx_byte_i && rx_state != HSF_IDLE) begin
        if (frame_len != MAX_FRAME[11:0]) begin
          frame_len <= frame_len + 12'h001; // R7
        end
        case (rx_state)
          HSF_ADDR_HI: begin
            hi_byte <= rx_data_i;
            rx_state <= HSF_ADDR_LO;
          end
          HSF_ADDR_LO: begin
            rx_state <= HSF_BODY;
            if (cfg[CFG_TWO_BYTE] && !cfg[CFG_SS7]) begin
              // R1 R4: match a has priority over match b
              if (hi_byte[7:2] == high_addr_match_a[7:2]) begin
                addr_result_hi <= hi_byte[1] ? HA_MATCH_A_C1 : HA_MATCH_A_C0; // R3
                fs_armed <= 1'b1;
              end else if (hi_byte == high_addr_match_b) begin
                addr_result_hi <= HA_MATCH_B; // R3
                fs_armed <= 1'b1;
              end else if (hi_byte == BCAST_A || hi_byte == BCAST_B) begin
                addr_result_hi <= HA_BCAST; // R1
                fs_armed <= 1'b1;
              end
            end else begin
              fs_armed <= 1'b1;
            end
            if (rx_data_i == low_addr_match_a) begin
              low_addr_result <= 1'b1; // R6
            end else if (rx_data_i == low_addr_match_b) begin
              low_addr_result <= 1'b0; // R6
            end
          end
          default: ;
        endcase
      end
      if (rx_frame_end_i && rx_state != HSF_IDLE) begin
        rx_state <= HSF_IDLE;
        rx_byte_count <= frame_len; // R7
        if (cfg[CFG_SS7]) begin
          addr_result_hi <= rx_su_type_i; // R5
        end
      end
    end
  end

  // fifo level, pool count, status byte append
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fifo_level <= '0;
      pool_cnt <= 6'h00;
      fifo_push_o <= 1'b0;
      fifo_data_o <= 8'h00;
    end else begin
      fifo_push_o <= 1'b0;
      if (rx_frame_end_i && rx_state != HSF_IDLE) begin
        fifo_push_o <= 1'b1; // R23
        fifo_data_o <= rx_status_i; // R23
        pool_cnt <= 6'h00;
      end else if (rx_byte_i && rx_state != HSF_IDLE) begin
        fifo_push_o <= 1'b1;
        fifo_data_o <= rx_data_i;
        pool_cnt <= (pool_cnt == 6'(POOL_BYTES)) ? 6'h01 : pool_cnt + 6'h01;
      end
      fifo_level <= fifo_level + (FIFO_BITS + 1)'(fifo_push_o)
                    - (FIFO_BITS + 1)'(host_pop_i && fifo_level != '0); // R8
    end
  end

  // frame start two bytes after valid start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fs_delay <= 2'h0;
    end else if (fs_armed) begin
      fs_delay <= 2'(FRAME_START_DELAY);
    end else if (rx_byte_i && fs_delay != 2'h0) begin
      fs_delay <= fs_delay - 2'h1; // R15
    end
  end

  // multiframe search timer and loopback detect timer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mf_timer <= 32'h0000_0000;
      loop_timer <= 32'h0000_0000;
      loop_detected <= 1'b0;
      sa6_prev <= 3'h0;
      prbs_prev <= 1'b0;
    end else begin
      sa6_prev <= sa6_state_i;
      prbs_prev <= prbs_sync_i;
      if (!cfg[CFG_MF_EN] || basic_align_lost_i || mf_sync_i || mf_timer == 32'(MF_TIMEOUT_CYCLES)) begin
        mf_timer <= 32'h0000_0000; // R16
      end else begin
        mf_timer <= mf_timer + 32'h0000_0001;
      end
      if (loop_detected) begin
        loop_timer <= 32'h0000_0000;
        if (!ber_low_i) begin
          loop_detected <= 1'b0; // R22
        end
      end else if ((loop_act_pat_i || loop_deact_pat_i) && ber_low_i) begin
        if (loop_timer == 32'(LOOP_DETECT_CYCLES - 1)) begin
          loop_detected <= 1'b1; // R22
        end else begin
          loop_timer <= loop_timer + 32'h0000_0001;
        end
      end else begin
        loop_timer <= 32'h0000_0000;
      end
    end
  end

  always_comb begin
    ev_0 = 8'h00;
    ev_1 = 8'h00;
    ev_0[BIT_MSG_END] = rx_frame_end_i && rx_state != HSF_IDLE; // R13
    ev_0[BIT_FRAME_START] = rx_byte_i && fs_delay == 2'h1; // R15
    ev_0[BIT_MF_TIMEOUT] = cfg[CFG_MF_EN] && !mf_sync_i && mf_timer == 32'(MF_TIMEOUT_CYCLES); // R16
    ev_0[BIT_MF_BEGIN] = mf_start_i; // R17
    ev_0[BIT_CAS_CHG] = cas_update_done_i && cas_differs_i && ts16_sync_i; // R18
    ev_0[BIT_CRC4] = crc4_done_i && crc4_fail_i; // R20
    ev_0[BIT_SA6_CHG] = !basic_align_lost_i && sa6_state_i != sa6_prev; // R21
    ev_0[BIT_POOL_FULL] = rx_byte_i && rx_state != HSF_IDLE && !rx_frame_end_i
                          && pool_cnt == 6'(POOL_BYTES - 1); // R14
    ev_1[BIT_LOOPBACK_CHG] = cfg[CFG_PRBS_MON] ? (prbs_sync_i != prbs_prev)
                             : (loop_detected != (loop_timer == 32'(LOOP_DETECT_CYCLES - 1)
                             && (loop_act_pat_i || loop_deact_pat_i) && ber_low_i
                             ? 1'b1 : loop_detected) || (loop_detected && !ber_low_i)); // R22
  end

  // sticky flags: set wins over read clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_0 <= RST_FLAGS;
      flags_1 <= RST_FLAGS;
    end else begin
      flags_0 <= (rd_flags_0 ? 8'h00 : flags_0) | (ev_0 & (cfg[CFG_SHOW_MASKED] ? 8'hff : ~mask_0)); // R10 R12
      flags_1 <= (rd_flags_1 ? 8'h00 : flags_1) | (ev_1 & (cfg[CFG_SHOW_MASKED] ? 8'hff : ~mask_1)); // R11 R12
    end
  end

  assign global_event_summary = {6'h00, |(flags_1 & ~mask_1), |(flags_0 & ~mask_0)}; // R12

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(flags_0 & ~mask_0) || |(flags_1 & ~mask_1); // R24
    end
  end

  // read mux
  always_comb begin
    case (adr_i)
      ADDR_FLAGS_0: next_dat = flags_0;
      ADDR_FLAGS_1: next_dat = flags_1;
      ADDR_COUNT_LOW: next_dat = {rx_byte_count[7:5], fifo_level[4:0]}; // R8 R9
      ADDR_COUNT_HIGH: next_dat = {4'h0, rx_byte_count[11:8]}; // R7
      ADDR_ADDR_RESULT: next_dat = {5'h00, addr_result_hi, low_addr_result}; // R2
      ADDR_HIGH_MATCH_A: next_dat = high_addr_match_a;
      ADDR_HIGH_MATCH_B: next_dat = high_addr_match_b;
      ADDR_LOW_MATCH_A: next_dat = low_addr_match_a;
      ADDR_LOW_MATCH_B: next_dat = low_addr_match_b;
      ADDR_MASK_0: next_dat = mask_0;
      ADDR_MASK_1: next_dat = mask_1;
      ADDR_CONFIG: next_dat = cfg;
      ADDR_SUMMARY: next_dat = global_event_summary;
      default: next_dat = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      dat_o <= (bus_req && !we_i) ? {24'h00_0000, next_dat} : 32'h0000_0000;
    end
  end

  property p_read_clears_0;
    @(posedge clk_i) disable iff (rst_i)
      rd_flags_0 && ev_0 == 8'h00 |=> flags_0 == 8'h00;
  endproperty
  a_read_clears_0: assert property (p_read_clears_0) else $error("flags 0 not cleared by read"); // R10

  property p_read_clears_1;
    @(posedge clk_i) disable iff (rst_i)
      rd_flags_1 && ev_1 == 8'h00 |=> flags_1 == 8'h00;
  endproperty
  a_read_clears_1: assert property (p_read_clears_1) else $error("flags 1 not cleared by read"); // R11

  property p_irq_follows;
    @(posedge clk_i) disable iff (rst_i)
      |(flags_0 & ~mask_0) |=> irq_o;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq missing for unmasked flag"); // R24

  property p_masked_hidden;
    @(posedge clk_i) disable iff (rst_i)
      (flags_0 & ~mask_0) == 8'h00 && (flags_1 & ~mask_1) == 8'h00 |=> !irq_o;
  endproperty
  a_masked_hidden: assert property (p_masked_hidden) else $error("irq from masked flags"); // R12

  property p_no_timeout_in_sync;
    @(posedge clk_i) disable iff (rst_i)
      mf_sync_i |-> !ev_0[BIT_MF_TIMEOUT];
  endproperty
  a_no_timeout_in_sync: assert property (p_no_timeout_in_sync) else $error("timeout in mf sync"); // R16

  property p_cas_sync_only;
    @(posedge clk_i) disable iff (rst_i)
      !ts16_sync_i |-> !ev_0[BIT_CAS_CHG];
  endproperty
  a_cas_sync_only: assert property (p_cas_sync_only) else $error("cas change outside sync"); // R18

  property p_status_appended;
    @(posedge clk_i) disable iff (rst_i)
      rx_frame_end_i && rx_state != HSF_IDLE |=> fifo_push_o && fifo_data_o == $past(rx_status_i);
  endproperty
  a_status_appended: assert property (p_status_appended) else $error("status byte not appended"); // R23

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
endmodule
`default_nettype wire

// ### pkg/hsf_pkg.sv
// hsf_pkg: register map, field positions, codes and timing for the rx status block
// assumes a 100 MHz system clock and a classic wishbone register bus
package hsf_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_FLAGS_0 = 8'h68;
  localparam logic [7:0] ADDR_FLAGS_1 = 8'h69;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h6a;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h6b;
  localparam logic [7:0] ADDR_ADDR_RESULT = 8'h6c;
  localparam logic [7:0] ADDR_HIGH_MATCH_A = 8'h70;
  localparam logic [7:0] ADDR_HIGH_MATCH_B = 8'h71;
  localparam logic [7:0] ADDR_LOW_MATCH_A = 8'h72;
  localparam logic [7:0] ADDR_LOW_MATCH_B = 8'h73;
  localparam logic [7:0] ADDR_MASK_0 = 8'h74;
  localparam logic [7:0] ADDR_MASK_1 = 8'h75;
  localparam logic [7:0] ADDR_CONFIG = 8'h76;
  localparam logic [7:0] ADDR_SUMMARY = 8'h77;
  // flags 0 bit positions
  localparam int BIT_MSG_END = 7;
  localparam int BIT_FRAME_START = 6;
  localparam int BIT_MF_TIMEOUT = 5;
  localparam int BIT_MF_BEGIN = 4;
  localparam int BIT_CAS_CHG = 3;
  localparam int BIT_CRC4 = 2;
  localparam int BIT_SA6_CHG = 1;
  localparam int BIT_POOL_FULL = 0;
  // flags 1 bit position
  localparam int BIT_LOOPBACK_CHG = 0;
  // config bit positions
  localparam int CFG_SHOW_MASKED = 0;
  localparam int CFG_SS7 = 1;
  localparam int CFG_TWO_BYTE = 2;
  localparam int CFG_TRANSPARENT = 3;
  localparam int CFG_PRBS_MON = 4;
  localparam int CFG_MF_EN = 5;
  localparam int CFG_FMT_LO = 6;
  // reset values
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_MASK = 8'hff;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_ADDR = 8'h00;
  // fixed broadcast high bytes
  localparam logic [7:0] BCAST_A = 8'hfe;
  localparam logic [7:0] BCAST_B = 8'hfc;
  // high byte result codes, ss7 unit types and doubleframe format code
  localparam logic [1:0] HA_MATCH_B = 2'h0;
  localparam logic [1:0] HA_BCAST = 2'h1;
  localparam logic [1:0] HA_MATCH_A_C0 = 2'h2;
  localparam logic [1:0] HA_MATCH_A_C1 = 2'h3;
  localparam logic [1:0] SU_INVALID = 2'h0;
  localparam logic [1:0] SU_FILL_IN = 2'h1;
  localparam logic [1:0] SU_LINK_STAT = 2'h2;
  localparam logic [1:0] SU_MESSAGE = 2'h3;
  localparam logic [1:0] FMT_DOUBLE_512 = 2'h0;
  // sizes
  localparam int POOL_BYTES = 32;
  localparam int MAX_FRAME = 4095;
  localparam int FRAME_START_DELAY = 2;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int MF_TIMEOUT_MS = 8;
  localparam int MF_TIMEOUT_CYC = MF_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int LOOP_DETECT_MS = 25;
  localparam int LOOP_DETECT_CYC = LOOP_DETECT_MS * 1000 * CLK_MHZ;
endpackage

// ### bench/hsf_host_model.sv
// hsf_host_model: classic wishbone host that reads and writes the status registers
// assumes one clock; the bench calls wb_xfer hierarchically right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module hsf_host_model (
  input wire logic clk_i, // system clock
  input wire logic ack_i, // slave ack
  input wire logic [31:0] dat_i, // read data
  output logic cyc_o, // cycle
  output logic stb_o, // strobe
  output logic we_o, // write
  output logic [7:0] adr_o, // byte address
  output logic [3:0] sel_o, // byte lanes
  output logic [31:0] dat_o // write data
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end

  // request held until ack is sampled high, then released for one cycle
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'h1;
    dat_o <= {24'h00_0000, d};
    // waits for ack however long; only the bench timeout ends a hang
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    q = dat_i[7:0];
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    // released lines do not keep the last value
    adr_o <= ~a;
    dat_o <= ~{24'h00_0000, d};
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
// testbench: register-level checks of the rx status and event flag block
// assumes hsf_host_model for bus cycles and shortened timeout parameters on the dut
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hsf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, irq, push;
  logic deact_pat = 1'b0;
  logic prbs = 1'b0;
  logic [7:0] adr, fdata;
  logic [7:0] last_push = 8'h00;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [6:0] pv = '0; // byte, open, end, mf start, cas done, crc4 done, pop
  logic [7:0] rx_data = 8'h00;
  logic [7:0] rx_status = 8'h00;
  logic [1:0] su = 2'h0;
  logic align_lost = 1'b1;
  logic mf_sync = 1'b0;
  logic cas_diff = 1'b0;
  logic ts16 = 1'b0;
  logic crc_fail = 1'b0;
  logic [2:0] sa6 = 3'h0;
  logic act_pat = 1'b0;
  logic ber_low = 1'b0;
  logic [23:0] tbl [6] = '{24'h40_1205, 24'h42_3406, 24'h80_1201, 24'hfe_3402, 24'hfc_1203, 24'h40_3404};
  int n_mismatch = 0;
  int checks = 0;
  int cyc_cnt = 0;

  hsf_host_model u_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  hsf_rx_status #(.MF_TIMEOUT_CYCLES(20), .LOOP_DETECT_CYCLES(10)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .irq_o(irq), .rx_byte_i(pv[0]), .rx_data_i(rx_data),
    .rx_frame_open_i(pv[1]), .rx_frame_end_i(pv[2]), .rx_status_i(rx_status), .rx_su_type_i(su),
    .host_pop_i(pv[6]), .fifo_to_fifo_o_unused_i(1'b0), .fifo_data_o(fdata), .fifo_push_o(push),
    .basic_align_lost_i(align_lost), .mf_sync_i(mf_sync), .mf_start_i(pv[3]), .cas_update_done_i(pv[4]),
    .cas_differs_i(cas_diff), .ts16_sync_i(ts16), .crc4_done_i(pv[5]), .crc4_fail_i(crc_fail),
    .sa6_state_i(sa6), .loop_act_pat_i(act_pat), .loop_deact_pat_i(deact_pat), .ber_low_i(ber_low),
    .prbs_sync_i(prbs));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (push === 1'b1) last_push <= fdata;
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_irq(input logic exp);
    @(negedge clk_i);
    chk({7'h00, irq}, {7'h00, exp});
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_host.wb_xfer(1'b1, a, d, q);
  endtask

  task automatic rdm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] q;
    u_host.wb_xfer(1'b0, a, 8'h00, q);
    chk(q & m, exp);
  endtask

  task automatic pulse(input int i);
    pv[i] <= 1'b1;
    @(posedge clk_i);
    pv <= '0;
    @(posedge clk_i);
  endtask

  task automatic byte_in(input logic [7:0] b);
    rx_data <= b;
    pulse(0);
  endtask

  task automatic frame_end(input logic [7:0] st);
    rx_status <= st;
    pulse(2);
    repeat (3) @(posedge clk_i);
  endtask

  task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] st);
    pulse(1);
    byte_in(b0);
    byte_in(b1);
    byte_in(8'h55);
    byte_in(8'haa);
    frame_end(st);
  endtask

  task automatic finish_test();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdm(ADDR_FLAGS_0, 8'hff, RST_FLAGS);
    rdm(ADDR_FLAGS_1, 8'hff, RST_FLAGS);
    rdm(ADDR_MASK_0, 8'hff, RST_MASK);
    rdm(ADDR_CONFIG, 8'hff, RST_CONFIG);
    rdm(8'h80, 8'hff, 8'h00);
    wr(ADDR_FLAGS_0, 8'hff);
    rdm(ADDR_FLAGS_0, 8'hff, 8'h00);
    // shown while masked: flagged, but no irq and no summary
    wr(ADDR_CONFIG, 8'h01);
    crc_fail <= 1'b1;
    pulse(5);
    chk_irq(1'b0);
    rdm(ADDR_SUMMARY, 8'hff, 8'h00);
    rdm(ADDR_FLAGS_0, 8'hff, 8'h04);
    rdm(ADDR_FLAGS_0, 8'hff, 8'h00);
    wr(ADDR_MASK_0, 8'h00);
    wr(ADDR_MASK_1, 8'h00);
    wr(ADDR_CONFIG, 8'h00);
    crc_fail <= 1'b0;
    pulse(5);
    rdm(ADDR_FLAGS_0, 8'hff, 8'h00);
    pulse(3);
    chk_irq(1'b1);
    rdm(ADDR_SUMMARY, 8'hff, 8'h01);
    rdm(ADDR_FLAGS_0, 8'hff, 8'h10);
    chk_irq(1'b0);
    ts16 <= 1'b1;
    cas_diff <= 1'b1;
    pulse(4);
    rdm(ADDR_FLAGS_0, 8'hff, 8'h08);
    cas_diff <= 1'b0;
    pulse(4);
    rdm(ADDR_FLAGS_0, 8'hff, 8'h00);
    ts16 <= 1'b0;
    cas_diff <= 1'b1;
    pulse(4);
    rdm(ADDR_FLAGS_0, 8'hff, 8'h00);
    align_lost <= 1'b0;
    sa6 <= 3'h2;
    repeat (4) @(posedge clk_i);
    rdm(ADDR_FLAGS_0, 8'hff, 8'h02);
    // transparent frame: start flag, pool full, then end with status byte
    wr(ADDR_CONFIG, 8'h08);
    pulse(1);
    byte_in(8'h01);
    rdm(ADDR_FLAGS_0, 8'hff, 8'h00);
    byte_in(8'h02);
    rdm(ADDR_FLAGS_0, 8'hff, 8'h40);
    for (int i = 2; i < 31; i++) byte_in(8'(i));
    rdm(ADDR_FLAGS_0, 8'hff, 8'h00);
    byte_in(8'h1f);
    rdm(ADDR_FLAGS_0, 8'hff, 8'h01);
    for (int i = 0; i < 32; i++) pulse(6);
    byte_in(8'h20);
    frame_end(8'ha5);
    rdm(ADDR_FLAGS_0, 8'hff, 8'h80);
    chk(last_push, 8'ha5);
    rdm(ADDR_COUNT_HIGH, 8'h0f, 8'h00);
    rdm(ADDR_COUNT_LOW, 8'hff, 8'h22);
    wr(ADDR_CONFIG, 8'h04);
    wr(ADDR_HIGH_MATCH_A, 8'h40);
    wr(ADDR_HIGH_MATCH_B, 8'h80);
    wr(ADDR_LOW_MATCH_A, 8'h12);
    wr(ADDR_LOW_MATCH_B, 8'h34);
    for (int i = 0; i < 6; i++) begin
      if (i == 5) wr(ADDR_HIGH_MATCH_B, 8'h40);
      frame(tbl[i][23:16], tbl[i][15:8], 8'h00);
      rdm(ADDR_ADDR_RESULT, 8'h07, tbl[i][7:0]);
    end
    wr(ADDR_CONFIG, 8'h06);
    for (int i = 0; i < 4; i++) begin
      su <= 2'(i);
      frame(8'h40, 8'h12, 8'h00);
      rdm(ADDR_ADDR_RESULT, 8'h06, {5'h00, 2'(i), 1'b0});
    end
    wr(ADDR_CONFIG, 8'h20);
    repeat (40) @(posedge clk_i);
    rdm(ADDR_FLAGS_0, 8'h20, 8'h20);
    mf_sync <= 1'b1;
    @(posedge clk_i);
    rdm(ADDR_FLAGS_0, 8'hdf, 8'h00);
    repeat (40) @(posedge clk_i);
    rdm(ADDR_FLAGS_0, 8'h20, 8'h00);
    wr(ADDR_CONFIG, 8'h00);
    act_pat <= 1'b1;
    ber_low <= 1'b1;
    repeat (30) @(posedge clk_i);
    rdm(ADDR_FLAGS_1, 8'hff, 8'h01);
    rdm(ADDR_FLAGS_1, 8'hff, 8'h00);
    ber_low <= 1'b0;
    repeat (5) @(posedge clk_i);
    rdm(ADDR_FLAGS_1, 8'hff, 8'h01);
    act_pat <= 1'b0;
    deact_pat <= 1'b1;
    ber_low <= 1'b1;
    repeat (30) @(posedge clk_i);
    rdm(ADDR_FLAGS_1, 8'hff, 8'h01);
    wr(ADDR_CONFIG, 8'h10);
    prbs <= 1'b1;
    repeat (3) @(posedge clk_i);
    rdm(ADDR_FLAGS_1, 8'hff, 8'h01);
    finish_test();
  end
endmodule
`default_nettype wire
